// ==== core/sgl_pkg.sv ====
package sgl_pkg;

	// processor local bus
	localparam int ADDR_W        = 32;
	localparam int DATA_W        = 32;
	localparam int BYTE_W        = 8;

	// i/o window: top bit clear, next sixteen bits set
	localparam int IO_TAG_HI     = 30;
	localparam int IO_TAG_LO     = 15;
	localparam int DEV_HI        = 14;
	localparam int DEV_LO        = 5;
	localparam int DEV_W         = DEV_HI - DEV_LO + 1;
	localparam logic [DEV_W-1:0] PIC_DEV = 10'h000;
	localparam logic [DEV_W-1:0] SCC_DEV = 10'h001;

	// register selects taken from the latched address
	localparam int PIC_REG_BIT   = 2;
	localparam int SCC_CHAN_BIT  = 2;
	localparam int SCC_DC_BIT    = 3;

	// timing control counter and per-select wait counts
	localparam int CNT_W         = 4;
	localparam logic [CNT_W-1:0] STROBE_AT = 4'h1;
	localparam logic [CNT_W-1:0] PIC_WAIT  = 4'h4;
	localparam logic [CNT_W-1:0] SCC_WAIT  = 4'h6;
	localparam logic [CNT_W-1:0] DFLT_WAIT = 4'h3;

	// processor: cycles from first ready to second acknowledge
	localparam int CPU_IRQ_IN_ACK_N_GAP      = 5;
	localparam int GAP_W         = 3;

	// vector rotation
	localparam int ROT           = 3;

	function automatic logic [BYTE_W-1:0] from_pic(input logic [BYTE_W-1:0] v);
		from_pic = ~{v[BYTE_W-ROT-1:0], v[BYTE_W-1:BYTE_W-ROT]};
	endfunction

	function automatic logic [BYTE_W-1:0] to_pic(input logic [BYTE_W-1:0] v);
		logic [BYTE_W-1:0] n;
		n = ~v;
		to_pic = {n[ROT-1:0], n[BYTE_W-1:ROT]};
	endfunction

	function automatic logic is_dev(input logic [ADDR_W-1:0] a,
		input logic [DEV_W-1:0] dev);
		is_dev = !a[ADDR_W-1] && (&a[IO_TAG_HI:IO_TAG_LO])
			&& (a[DEV_HI:DEV_LO] == dev);
	endfunction

endpackage

// ==== core/sgl_bus_if.sv ====
`timescale 1ns/1ps
interface sgl_bus_if;
	import sgl_pkg::*;

	logic              addr_strobe_n;
	logic              data_enable_n;
	logic              wr_not_rd;
	logic              cpu_irq_in_ack_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data;
	logic [DATA_W-1:0] rd_data;
	logic              rd_oe_n;
	logic              ready_n;
	logic              cpu_irq_in;

	modport glue (
		input  addr_strobe_n,
		input  data_enable_n,
		input  wr_not_rd,
		input  cpu_irq_in_ack_n,
		input  addr,
		input  wr_data,
		output rd_data,
		output rd_oe_n,
		output ready_n,
		output cpu_irq_in
	);

	modport cpu (
		output addr_strobe_n,
		output data_enable_n,
		output wr_not_rd,
		output cpu_irq_in_ack_n,
		output addr,
		output wr_data,
		input  rd_data,
		input  rd_oe_n,
		input  ready_n,
		input  cpu_irq_in
	);
endinterface

// ==== core/sgl_glue.sv ====
// Function
// - vector to processor: inverted, rotated left three
// - processor priority is vector divided by eight
// - controller priority zero maps to processor highest
// - top two vector bits free for grouping
// - glue pre-compensates controller register writes
// - controller request drives processor interrupt input
// - processor pulses acknowledge twice per interrupt
// - acknowledge without controller select yields ready
// - second acknowledge five cycles after first ready
// - processor captures vector on second acknowledge
// - acknowledge enables buffer toward processor
// - second ready ends acknowledge cycle
// - A2 picks one of two controller registers
// - buffer enable follows gated write command
// - ready ends each peripheral register transfer
// - read or write command from write-not-read
// - selects decoded from latched address
// - A2 drives serial channel select
// - A3 drives serial data-or-command select
// - controller returns vector after resolving priority
// - four-bit counter from strobe and enable to ready
`timescale 1ns/1ps
module sgl_glue
	import sgl_pkg::*;
#(
	parameter logic [CNT_W-1:0] PIC_WAIT_P = PIC_WAIT,
	parameter logic [CNT_W-1:0] SCC_WAIT_P = SCC_WAIT,
	parameter logic [CNT_W-1:0] DFLT_WAIT_P = DFLT_WAIT
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// processor side
	sgl_bus_if.glue                bus,
	// peripheral selects and commands
	output logic                   pic_select_n,
	output logic                   scc_select_n,
	output logic                   pic_ack_n,
	output logic                   io_rd_n,
	output logic                   io_wr_n,
	// peripheral address lines
	output logic                   pic_reg_sel,
	output logic                   scc_chan_a,
	output logic                   scc_data_ncmd,
	// peripheral byte bus
	input  wire logic [BYTE_W-1:0] per_data_in,
	output logic      [BYTE_W-1:0] per_data_out,
	output logic                   per_data_oe_n,
	// controller request pin
	input  wire logic              pic_irq
);

	// synchronised peripheral reads need two cycles before capture
	if (PIC_WAIT_P <= STROBE_AT + 4'h2 || SCC_WAIT_P <= STROBE_AT + 4'h2
		|| DFLT_WAIT_P <= STROBE_AT)
	begin : g_wait_chk
		$error("wait counts too short for strobe and synchroniser");
	end

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic              irq_s1_q;
	logic              irq_s2_q;
	logic [BYTE_W-1:0] din_s1_q;
	logic [BYTE_W-1:0] din_s2_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_s1_q <= 1'b0;
			irq_s2_q <= 1'b0;
			din_s1_q <= 8'h00;
			din_s2_q <= 8'h00;
		end
		else
		begin
			irq_s1_q <= pic_irq;
			irq_s2_q <= irq_s1_q;
			din_s1_q <= per_data_in;
			din_s2_q <= din_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address latch and decode

	logic              busy_q;
	logic              ready_q;
	logic [ADDR_W-1:0] addr_q;
	logic              wr_q;
	logic              cpu_irq_in_ack_n_q;
	logic              start;
	logic              pic_hit;
	logic              scc_hit;

	assign start = !busy_q && !bus.addr_strobe_n;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			addr_q <= 32'h0000_0000;
			wr_q   <= 1'b0;
			cpu_irq_in_ack_n_q <= 1'b0;
		end
		else if (start)
		begin
			addr_q <= bus.addr;
			wr_q   <= bus.wr_not_rd;
			cpu_irq_in_ack_n_q <= !bus.cpu_irq_in_ack_n;
		end
	end

	// decoding after the latch keeps selects stable all cycle
	assign pic_hit = !cpu_irq_in_ack_n_q && is_dev(addr_q, PIC_DEV);
	assign scc_hit = !cpu_irq_in_ack_n_q && is_dev(addr_q, SCC_DEV);

	////////////////////////////////////////////////////////////////////////
	// timing control counter

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] wait_cnt;
	logic             run;
	logic             strobe;

	always_comb
	begin
		if (cpu_irq_in_ack_n_q || pic_hit)
			wait_cnt = PIC_WAIT_P;
		else if (scc_hit)
			wait_cnt = SCC_WAIT_P;
		else
			wait_cnt = DFLT_WAIT_P;
	end

	assign run = busy_q && !bus.data_enable_n && !ready_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			busy_q <= 1'b0;
		else if (start)
			busy_q <= 1'b1;
		else if (ready_q)
			busy_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cnt_q <= 4'h0;
		else if (start)
			cnt_q <= 4'h0;
		else if (run && cnt_q != 4'hF)
			cnt_q <= cnt_q + 4'h1;
	end

	// unmapped addresses still get ready so the bus never hangs
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ready_q <= 1'b0;
		else
			ready_q <= run && cnt_q == wait_cnt;
	end

	assign bus.ready_n = !ready_q;

	////////////////////////////////////////////////////////////////////////
	// selects and commands

	assign strobe = run && cnt_q >= STROBE_AT;

	assign pic_select_n  = !(busy_q && pic_hit);
	assign scc_select_n  = !(busy_q && scc_hit);
	assign pic_ack_n     = !(strobe && cpu_irq_in_ack_n_q);
	assign io_rd_n       = !(strobe && !cpu_irq_in_ack_n_q && !wr_q);
	assign io_wr_n       = !(strobe && !cpu_irq_in_ack_n_q && wr_q);
	assign pic_reg_sel   = addr_q[PIC_REG_BIT];
	assign scc_chan_a    = addr_q[SCC_CHAN_BIT];
	assign scc_data_ncmd = addr_q[SCC_DC_BIT];

	////////////////////////////////////////////////////////////////////////
	// byte buffer

	logic [BYTE_W-1:0] wbyte_q;
	logic [DATA_W-1:0] rd_data_q;
	logic              irq_q;

	// write path applies the inverse of the vector wiring, so software
	// need not pre-compensate controller writes
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			wbyte_q <= 8'h00;
		else if (start)
			wbyte_q <= is_dev(bus.addr, PIC_DEV) ?
				to_pic(bus.wr_data[BYTE_W-1:0]) :
				bus.wr_data[BYTE_W-1:0];
	end

	assign per_data_out  = wbyte_q;
	assign per_data_oe_n = !(strobe && !cpu_irq_in_ack_n_q && wr_q
		&& (pic_hit || scc_hit));

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rd_data_q <= 32'h0000_0000;
		else if (run && cnt_q == wait_cnt && !wr_q)
		begin
			if (cpu_irq_in_ack_n_q || pic_hit)
				rd_data_q <= {24'h00_0000, from_pic(din_s2_q)};
			else
				rd_data_q <= {24'h00_0000, din_s2_q};
		end
	end

	assign bus.rd_data = rd_data_q;
	assign bus.rd_oe_n = !(busy_q && !wr_q
		&& (cpu_irq_in_ack_n_q || pic_hit || scc_hit));

	////////////////////////////////////////////////////////////////////////
	// interrupt request

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			irq_q <= 1'b0;
		else
			irq_q <= irq_s2_q;
	end

	assign bus.cpu_irq_in = irq_q;

endmodule // sgl_glue

// ==== core/sgl_cpu.sv ====
`timescale 1ns/1ps
module sgl_cpu
	import sgl_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// bus toward the glue
	sgl_bus_if.cpu                 bus,
	// interrupt control setting
	input  wire logic              ext_int_en,
	// user requests
	input  wire logic              req,
	input  wire logic              req_wr,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	output logic                   req_ready,
	output logic                   done,
	output logic      [DATA_W-1:0] rdata,
	// vector out
	output logic                   vec_valid,
	output logic      [BYTE_W-1:0] vec
);

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_ADDR = 2'b01,
		S_DATA = 2'b10,
		S_GAP  = 2'b11
	} sgl_state_t;

	sgl_state_t        st_q;
	logic              cpu_irq_in_ack_n_q;
	logic              second_q;
	logic              wr_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [GAP_W-1:0]  gap_q;
	logic              take_int;

	// interrupts win over user requests when both wait
	assign take_int  = ext_int_en && bus.cpu_irq_in;
	assign req_ready = st_q == S_IDLE && !take_int;

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q     <= S_IDLE;
			cpu_irq_in_ack_n_q   <= 1'b0;
			second_q <= 1'b0;
			gap_q    <= 3'h0;
		end
		else
		begin
			unique case (st_q)
				S_IDLE:
				begin
					if (take_int)
					begin
						cpu_irq_in_ack_n_q   <= 1'b1;
						second_q <= 1'b0;
						st_q     <= S_ADDR;
					end
					else if (req)
					begin
						cpu_irq_in_ack_n_q <= 1'b0;
						st_q   <= S_ADDR;
					end
				end
				S_ADDR:
					st_q <= S_DATA;
				S_DATA:
				begin
					if (!bus.ready_n)
					begin
						if (cpu_irq_in_ack_n_q && !second_q)
						begin
							second_q <= 1'b1;
							gap_q    <= 3'h0;
							st_q     <= S_GAP;
						end
						else
							st_q <= S_IDLE;
					end
				end
				S_GAP:
				begin
					if (gap_q == GAP_W'(CPU_IRQ_IN_ACK_N_GAP - 2))
						st_q <= S_ADDR;
					else
						gap_q <= gap_q + 3'h1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_q    <= 1'b0;
			addr_q  <= 32'h0000_0000;
			wdata_q <= 32'h0000_0000;
		end
		else if (st_q == S_IDLE)
		begin
			wr_q    <= req_wr && !take_int;
			addr_q  <= take_int ? 32'h0000_0000 : req_addr;
			wdata_q <= req_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus drive and capture

	assign bus.addr_strobe_n = st_q != S_ADDR;
	assign bus.data_enable_n = !(st_q == S_ADDR || st_q == S_DATA);
	assign bus.cpu_irq_in_ack_n    = !(cpu_irq_in_ack_n_q
		&& (st_q == S_ADDR || st_q == S_DATA));
	assign bus.wr_not_rd     = wr_q;
	assign bus.addr          = addr_q;
	assign bus.wr_data       = wdata_q;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			done      <= 1'b0;
			rdata     <= 32'h0000_0000;
			vec_valid <= 1'b0;
			vec       <= 8'h00;
		end
		else
		begin
			done      <= st_q == S_DATA && !bus.ready_n && !cpu_irq_in_ack_n_q;
			vec_valid <= st_q == S_DATA && !bus.ready_n
				&& cpu_irq_in_ack_n_q && second_q;
			if (st_q == S_DATA && !bus.ready_n && !cpu_irq_in_ack_n_q && !wr_q)
				rdata <= bus.rd_data;
			if (st_q == S_DATA && !bus.ready_n && cpu_irq_in_ack_n_q && second_q)
				vec <= bus.rd_data[BYTE_W-1:0];
		end
	end

endmodule // sgl_cpu

// ==== verif/sgl_glue_assertions.sv ====
`timescale 1ns/1ps
module sgl_glue_assertions
	import sgl_pkg::*;
(
	// clock and reset
	input wire logic              clk,
	input wire logic              nrst,
	// bus signals
	input wire logic              addr_strobe_n,
	input wire logic              data_enable_n,
	input wire logic              cpu_irq_in_ack_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic              rd_oe_n,
	input wire logic              ready_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////
	logic io;
	logic pic;
	logic scc;
	logic ack_odd_q;
	assign io  = !addr[ADDR_W-1] && (&addr[IO_TAG_HI:IO_TAG_LO]);
	assign pic = io && addr[DEV_HI:DEV_LO] == PIC_DEV;
	assign scc = io && addr[DEV_HI:DEV_LO] == SCC_DEV;
	// parity of acknowledge pulses tells first from second
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ack_odd_q <= 1'b0;
		else if ($fell(cpu_irq_in_ack_n))
			ack_odd_q <= !ack_odd_q;
	end
	sequence first_ack_ready;
		$fell(ready_n) && ack_odd_q;
	endsequence
	sequence second_ack;
		##5 $fell(cpu_irq_in_ack_n);
	endsequence
	////////////////////////////////////////
	a_ready_one_cycle: assert property ($fell(ready_n) |=> ready_n)
		else $error("ready longer than one cycle");
	a_ack_gap: assert property (first_ack_ready |-> second_ack)
		else $error("second acknowledge off time");
	a_ack_ready: assert property (!addr_strobe_n && !cpu_irq_in_ack_n
		|-> ready_n [*6] ##1 !ready_n) else $error("ack ready time");
	a_pic_wait: assert property (!addr_strobe_n && cpu_irq_in_ack_n && pic
		|-> ready_n [*6] ##1 !ready_n) else $error("pic ready time");
	a_scc_wait: assert property (!addr_strobe_n && cpu_irq_in_ack_n && scc
		|-> ready_n [*8] ##1 !ready_n) else $error("scc ready time");
	a_dflt_wait: assert property (!addr_strobe_n && !pic && !scc &&
		cpu_irq_in_ack_n |-> ready_n [*5] ##1 !ready_n) else $error("dflt time");
	a_byte_lane: assert property (rd_data[DATA_W-1:BYTE_W] == '0)
		else $error("upper read bytes not zero");
	a_no_overlap: assert property (!ready_n |-> addr_strobe_n)
		else $error("strobe during ready");
	a_addr_held: assert property (!addr_strobe_n |=>
		($stable(addr) && !data_enable_n) [*4]) else $error("addr moved");
	a_ack_buf_on: assert property (!cpu_irq_in_ack_n && !ready_n |-> !rd_oe_n)
		else $error("vector buffer not driving");
	a_ack_ends: assert property (!cpu_irq_in_ack_n && !ready_n && !ack_odd_q
		|=> cpu_irq_in_ack_n) else $error("acknowledge cycle not ended");
endmodule // sgl_glue_assertions

// ==== verif/slave_peripheral_glue_tb.sv ====
`timescale 1ns/1ps
module slave_peripheral_glue_tb;
	import sgl_pkg::*;
	logic              clk = 1'b0;
	logic              nrst = 1'b0;
	logic              ext_int_en = 1'b0;
	logic              req = 1'b0;
	logic              req_wr = 1'b0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic [BYTE_W-1:0] per_data_in = '0;
	logic              pic_irq = 1'b0;
	logic              req_ready, done, vec_valid, pic_sn, scc_sn;
	logic              io_rd_n, io_wr_n, reg_sel, chan_a, dnc, oe_n;
	logic [DATA_W-1:0] rdata;
	logic [BYTE_W-1:0] vec, pdo, exp_b, b8;
	logic [32:0]       notes[$];
	logic              ack_n;
	logic [32:0]       exp_n;
	logic [31:0]       got;
	logic [1:0]        sel_e;
	int                failures = 0;
	int                checked = 0;
	int                cyc = 0;
	int                k;
	int                seed = 32'h463d_d65e;
	sgl_bus_if bus();
	////////////////////////////////////////
	sgl_glue sgl_glue_i (.clk(clk), .nrst(nrst), .bus(bus),
		.pic_select_n(pic_sn), .scc_select_n(scc_sn), .pic_ack_n(ack_n),
		.io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .pic_reg_sel(reg_sel),
		.scc_chan_a(chan_a), .scc_data_ncmd(dnc), .per_data_in(per_data_in),
		.per_data_out(pdo), .per_data_oe_n(oe_n), .pic_irq(pic_irq));
	sgl_cpu sgl_cpu_i (.clk(clk), .nrst(nrst), .bus(bus),
		.ext_int_en(ext_int_en), .req(req), .req_wr(req_wr),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.done(done), .rdata(rdata), .vec_valid(vec_valid), .vec(vec));
	sgl_glue_assertions sgl_glue_assertions_i (.clk(clk), .nrst(nrst),
		.addr_strobe_n(bus.addr_strobe_n), .data_enable_n(bus.data_enable_n),
		.cpu_irq_in_ack_n(bus.cpu_irq_in_ack_n), .addr(bus.addr),
		.rd_data(bus.rd_data), .rd_oe_n(bus.rd_oe_n),
		.ready_n(bus.ready_n));
	////////////////////////////////////////
	initial
	begin
		forever #5 clk = ~clk;
	end
	// cuts a hang short
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			failures++;
			wrap_up();
		end
	end
	task automatic chk(input logic [32:0] e, input logic [31:0] g);
		if (!e[32])
		begin
			checked++;
			if (g !== e[31:0])
			begin
				failures++;
				$display("unexpected at %0t: exp %h got %h", $time, e[31:0], g);
			end
		end
	endtask
	task automatic wrap_up();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////
	always @(negedge clk)
	begin
		if (done === 1'b1 || vec_valid === 1'b1)
		begin
			exp_n = notes.size() ? notes.pop_front() : 33'h0_ffff_ffff;
			got = done ? rdata : {24'h0, vec};
			chk(exp_n, got);
		end
		if (bus.cpu_irq_in_ack_n && (!io_rd_n || !io_wr_n))
		begin
			sel_e = req_addr[DEV_HI:DEV_LO] == PIC_DEV ? 2'h1
				: req_addr[DEV_HI:DEV_LO] == SCC_DEV ? 2'h2 : 2'h3;
			exp_n = {17'h0, sel_e, req_wr ? 2'h2 : 2'h1, req_addr[2],
				req_addr[2], req_addr[3], !req_wr, exp_b};
			got = {16'h0, pic_sn, scc_sn, io_rd_n, io_wr_n, reg_sel, chan_a,
				dnc, oe_n, pdo};
			chk(exp_n, got);
		end
		if (ack_n === 1'b0)
			chk(33'h0, {31'h0, bus.cpu_irq_in_ack_n});
	end
	// unmapped places are only read: nothing should drive their byte
	task automatic xfer(input logic w, input logic [DEV_W-1:0] d,
		input logic [2:0] r);
		logic [7:0] b;
		b = 8'($random(seed));
		@(posedge clk);
		req <= 1'b1;
		req_wr <= w;
		req_addr <= {1'b0, 16'hffff, d, r, 2'h0};
		req_wdata <= {24'h0, b};
		per_data_in <= b;
		exp_b <= (d == PIC_DEV) ? {~b[2:0], ~b[7:3]} : b;
		notes.push_back(w ? 33'h1_0000_0000 : (d == PIC_DEV) ?
			{25'h0, ~b[4:0], ~b[7:5]} : {25'h0, b});
		@(negedge clk);
		while (req_ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		req <= 1'b0;
		while (done !== 1'b1) @(negedge clk);
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 24; i++)
		begin
			k = $random(seed) & 3;
			xfer(k < 2 && ($random(seed) & 1) != 0,
				k == 0 ? PIC_DEV : k == 1 ? SCC_DEV : 10'h3ff,
				3'($random(seed)));
		end
		@(posedge clk);
		pic_irq <= 1'b1;
		repeat (20)
		begin
			@(negedge clk);
			chk(33'h1, {31'h0, bus.cpu_irq_in_ack_n});
		end
		chk(33'h1, {31'h0, bus.cpu_irq_in});
		for (int i = 0; i < 3; i++)
		begin
			@(posedge clk);
			b8 = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'($random(seed));
			per_data_in <= b8;
			pic_irq <= 1'b1;
			ext_int_en <= 1'b1;
			notes.push_back({25'h0, ~b8[4:0], ~b8[7:5]});
			while (bus.cpu_irq_in_ack_n !== 1'b0) @(negedge clk);
			@(posedge clk);
			pic_irq <= 1'b0;
			while (notes.size() != 0) @(negedge clk);
		end
		wrap_up();
	end
endmodule // slave_peripheral_glue_tb
